// >>> inc/sta_pkg.sv
// Shared constants and types of the spectrometer trigger and acquisition block.
// Assumes a single 20 MHz clock and a 32-bit classic Wishbone register port.
package sta_pkg;

  // Timing.
  localparam int unsigned CLK_HZ               = 20_000_000;
  localparam int unsigned MICRO_PER_SEC        = 1_000_000;
  localparam int unsigned TICKS_PER_US         = CLK_HZ / MICRO_PER_SEC;
  localparam int unsigned TICK_W               = 5;
  localparam int unsigned RING_MIN_EXPOSURE_MS = 1;
  localparam logic [31:0] RING_MIN_EXPOSURE_US = 32'(RING_MIN_EXPOSURE_MS * 1000);

  // Widths and depths.
  localparam int unsigned DW        = 32;
  localparam int unsigned AW        = 8;
  localparam int unsigned PIX_W     = 16;
  localparam int unsigned ACC_W     = 24;
  localparam int unsigned AVG_W     = 8;
  localparam int unsigned FRAME_W   = 16;
  localparam int unsigned IDX_W     = 12;
  localparam int unsigned FRAME_MAX = 2086;
  localparam int unsigned RING_AW   = 12;
  localparam int unsigned RING_DEPTH = 1 << RING_AW;

  // Register byte offsets.
  localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFS_EXPOSURE = 8'h04;
  localparam logic [AW-1:0] OFS_AVERAGE  = 8'h08;
  localparam logic [AW-1:0] OFS_FRAME    = 8'h0C;
  localparam logic [AW-1:0] OFS_XFER     = 8'h10;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h14;
  localparam logic [AW-1:0] OFS_MEASURED = 8'h18;
  localparam logic [AW-1:0] OFS_LIMITS   = 8'h1C;
  localparam logic [AW-1:0] OFS_WL_MIN   = 8'h20;
  localparam logic [AW-1:0] OFS_WL_MAX   = 8'h24;

  // Field positions.
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_EDGE_BIT  = 2;
  localparam int unsigned CTRL_START_BIT = 8;
  localparam int unsigned CTRL_STOP_BIT  = 9;
  localparam int unsigned STAT_TRIG_BIT  = 2;
  localparam int unsigned STAT_OVR_BIT   = 3;
  localparam int unsigned STAT_LVL_LSB   = 16;

  // Reset values.
  localparam logic [31:0]      EXPOSURE_RST = 32'h0000_03E8;
  localparam logic [AVG_W-1:0] AVERAGE_RST  = 8'h01;
  localparam logic [15:0]      FRAME_RST    = 16'h0826;
  localparam logic [15:0]      XFER_RST     = 16'h0100;
  localparam logic [15:0]      LIMIT_MIN_US = 16'h03E8;
  localparam logic [15:0]      LIMIT_MAX_MS = 16'h0FA0;

  typedef enum logic [1:0] {
    STA_IDLE   = 2'b00,
    STA_ARMED  = 2'b01,
    STA_EXPOSE = 2'b11
  } sta_state_t;

  typedef enum logic [1:0] {
    STA_MODE_GATED   = 2'b00,
    STA_MODE_LATCHED = 2'b01,
    STA_MODE_PULSE   = 2'b10,
    STA_MODE_EDGE    = 2'b11
  } sta_mode_t;

  // Applies Wishbone byte selects to a stored word.
  function automatic logic [DW-1:0] sta_merge(input logic [DW-1:0] old_w, input logic [DW-1:0] new_w,
                                              input logic [3:0] sel);
    logic [DW-1:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : sta_merge

endpackage : sta_pkg

// >>> verilog/sta_ring.sv
// Circular spectrum store between the pixel path and the bulk drain.
// Assumes the writer never stalls; the oldest word is dropped when full.
module sta_ring (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Write side
  input  wire logic                          wr_valid_i,
  input  wire logic [sta_pkg::PIX_W-1:0]     wr_data_i,
  // Read side
  output logic                               rd_valid_o,
  input  wire logic                          rd_ready_i,
  output logic [sta_pkg::PIX_W-1:0]          rd_data_o,
  // Status
  output logic [sta_pkg::RING_AW:0]          level_o,
  output logic                               drop_o
);

  logic [sta_pkg::PIX_W-1:0]   mem [sta_pkg::RING_DEPTH];
  logic [sta_pkg::RING_AW-1:0] wr_ptr;
  logic [sta_pkg::RING_AW-1:0] rd_ptr;
  logic [sta_pkg::RING_AW:0]   count;
  logic                        full;
  logic                        pop;
  logic                        adv_rd;

  assign full       = (count == (sta_pkg::RING_AW+1)'(sta_pkg::RING_DEPTH));
  assign rd_valid_o = (count != '0);
  assign pop        = rd_valid_o & rd_ready_i;
  // A stalled drain never blocks the writer; the oldest word gives way instead.
  assign drop_o     = wr_valid_i & full & ~pop;
  assign adv_rd     = pop | drop_o;
  assign rd_data_o  = mem[rd_ptr];
  assign level_o    = count;

  always_ff @(posedge clk_i) begin
    if (wr_valid_i) begin
      mem[wr_ptr] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (wr_valid_i) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (adv_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + {{sta_pkg::RING_AW{1'b0}}, wr_valid_i} - {{sta_pkg::RING_AW{1'b0}}, adv_rd};
    end
  end

endmodule : sta_ring

// >>> verilog/sta_acquire.sv
// Trigger handling, exposure timing, frame averaging and bulk drain of the spectrometer.
// Assumes a 20 MHz clock, a classic Wishbone master, an AFE pixel stream after each
// readout gate pulse, and a bulk IN endpoint that may stall with bulk_ready_i.
module sta_acquire #(
  parameter logic [31:0] WL_MIN_NM = 32'h0000_0000,
  parameter logic [31:0] WL_MAX_NM = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone register port
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [sta_pkg::AW-1:0]        wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [sta_pkg::DW-1:0]        wb_dat_i,
  output logic [sta_pkg::DW-1:0]             wb_dat_o,
  output logic                               wb_ack_o,
  // External trigger and sensor
  input  wire logic                          trigger_i,
  output logic                               readout_gate_pulse_o,
  input  wire logic                          pix_valid_i,
  input  wire logic [sta_pkg::PIX_W-1:0]     pix_data_i,
  // Bulk IN stream
  output logic                               bulk_valid_o,
  input  wire logic                          bulk_ready_i,
  output logic [sta_pkg::PIX_W-1:0]          bulk_data_o,
  output logic                               bulk_last_o
);

  // Registers.
  sta_pkg::sta_mode_t            mode;
  logic                          edge_falling;
  logic [31:0]                   exposure_time_micro;
  logic [sta_pkg::AVG_W-1:0]     average;
  logic [15:0]                   frame_len;
  logic [15:0]                   xfer_len;
  logic                          overrun;
  logic [31:0]                   measured_us;

  // Control state.
  sta_pkg::sta_state_t           state;
  sta_pkg::sta_state_t           next_state;
  logic [sta_pkg::TICK_W-1:0]    tick_cnt;
  logic [31:0]                   us_cnt;
  logic                          us_tick;
  logic                          restart_exp;
  logic                          gate;
  logic                          pulse_open;

  // Trigger path.
  logic                          trig_meta;
  logic                          trig_s;
  logic                          trig_d;
  logic                          trig_rise;
  logic                          trig_edge;

  // Bus decode.
  logic                          wb_req;
  logic                          wr_en;
  logic                          start_cmd;
  logic                          stop_cmd;
  logic [31:0]                   rd_mux;

  // Pixel path.
  logic [sta_pkg::ACC_W-1:0]     acc [sta_pkg::FRAME_MAX];
  logic [sta_pkg::IDX_W-1:0]     pix_idx;
  logic [sta_pkg::AVG_W-1:0]     avg_cnt;
  logic                          frame_active;
  logic                          pix_take;
  logic                          last_pass;
  logic                          last_pix;
  logic [sta_pkg::AVG_W-1:0]     avg_n;
  logic [sta_pkg::IDX_W-1:0]     frame_end;
  logic [sta_pkg::ACC_W-1:0]     acc_sum;
  logic [31:0]                   exp_eff;
  logic                          ring_wr_valid;
  logic [sta_pkg::PIX_W-1:0]     ring_wr_data;
  logic [sta_pkg::RING_AW:0]     ring_level;
  logic                          ring_drop;
  logic [15:0]                   xfer_cnt;
  logic [15:0]                   xfer_end;

  // Sum over the averaging window divided by the window length.
  function automatic logic [sta_pkg::PIX_W-1:0] avg_div(input logic [sta_pkg::ACC_W-1:0] sum,
                                                        input logic [sta_pkg::AVG_W-1:0] n);
    logic [sta_pkg::ACC_W-1:0] q;
    q = sum / {{(sta_pkg::ACC_W-sta_pkg::AVG_W){1'b0}}, n};
    return q[sta_pkg::PIX_W-1:0];
  endfunction : avg_div

  // Two flip-flop synchroniser; the second stage and a third, delayed flop feed detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_meta <= 1'b0;
      trig_s    <= 1'b0;
      trig_d    <= 1'b0;
    end else begin
      trig_meta <= trigger_i;
      trig_s    <= trig_meta;
      trig_d    <= trig_s;
    end
  end

  assign trig_rise = trig_s & ~trig_d;
  assign trig_edge = edge_falling ? (trig_d & ~trig_s) : trig_rise;

  // Wishbone slave: one wait state, ack drops after one cycle.
  assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en     = wb_req & wb_we_i;
  assign start_cmd = wr_en && (wb_adr_i == sta_pkg::OFS_CTRL) && wb_sel_i[1] && wb_dat_i[sta_pkg::CTRL_START_BIT];
  assign stop_cmd  = wr_en && (wb_adr_i == sta_pkg::OFS_CTRL) && wb_sel_i[1] && wb_dat_i[sta_pkg::CTRL_STOP_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      sta_pkg::OFS_CTRL: begin
        rd_mux[sta_pkg::CTRL_MODE_LSB +: 2] = mode;
        rd_mux[sta_pkg::CTRL_EDGE_BIT]      = edge_falling;
      end
      sta_pkg::OFS_EXPOSURE: rd_mux = exposure_time_micro;
      sta_pkg::OFS_AVERAGE:  rd_mux[sta_pkg::AVG_W-1:0] = average;
      sta_pkg::OFS_FRAME:    rd_mux[15:0] = frame_len;
      sta_pkg::OFS_XFER:     rd_mux[15:0] = xfer_len;
      sta_pkg::OFS_STATUS: begin
        rd_mux[1:0]                                        = state;
        rd_mux[sta_pkg::STAT_TRIG_BIT]                     = trig_s;
        rd_mux[sta_pkg::STAT_OVR_BIT]                      = overrun;
        rd_mux[sta_pkg::STAT_LVL_LSB +: sta_pkg::RING_AW+1] = ring_level;
      end
      sta_pkg::OFS_MEASURED: rd_mux = measured_us;
      sta_pkg::OFS_LIMITS:   rd_mux = {sta_pkg::LIMIT_MAX_MS, sta_pkg::LIMIT_MIN_US};
      sta_pkg::OFS_WL_MIN:   rd_mux = WL_MIN_NM;
      sta_pkg::OFS_WL_MAX:   rd_mux = WL_MAX_NM;
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // Configuration registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode                <= sta_pkg::STA_MODE_GATED;
      edge_falling        <= 1'b0;
      exposure_time_micro <= sta_pkg::EXPOSURE_RST;
      average             <= sta_pkg::AVERAGE_RST;
      frame_len           <= sta_pkg::FRAME_RST;
      xfer_len            <= sta_pkg::XFER_RST;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        sta_pkg::OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            mode         <= sta_pkg::sta_mode_t'(wb_dat_i[sta_pkg::CTRL_MODE_LSB +: 2]);
            edge_falling <= wb_dat_i[sta_pkg::CTRL_EDGE_BIT];
          end
        end
        sta_pkg::OFS_EXPOSURE: begin
          exposure_time_micro <= sta_pkg::sta_merge(exposure_time_micro, wb_dat_i, wb_sel_i);
        end
        sta_pkg::OFS_AVERAGE:  average   <= 8'(sta_pkg::sta_merge({24'h000000, average}, wb_dat_i, wb_sel_i));
        sta_pkg::OFS_FRAME:    frame_len <= 16'(sta_pkg::sta_merge({16'h0000, frame_len}, wb_dat_i, wb_sel_i));
        sta_pkg::OFS_XFER: begin
          xfer_len <= 16'(sta_pkg::sta_merge({16'h0000, xfer_len}, wb_dat_i, wb_sel_i));
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky overrun flag; a drop in the clearing cycle wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun <= 1'b0;
    end else if (ring_drop) begin
      overrun <= 1'b1;
    end else if (wr_en && wb_adr_i == sta_pkg::OFS_STATUS && wb_sel_i[0] && wb_dat_i[sta_pkg::STAT_OVR_BIT]) begin
      overrun <= 1'b0;
    end
  end

  // Microsecond time base, restarted at the start of each exposure.
  assign us_tick = (tick_cnt == sta_pkg::TICK_W'(sta_pkg::TICKS_PER_US - 1));
  assign pulse_open = (mode == sta_pkg::STA_MODE_PULSE) && (next_state == sta_pkg::STA_EXPOSE);
  // Short exposures are raised to the shortest one the readout can keep up with.
  assign exp_eff = (exposure_time_micro < sta_pkg::RING_MIN_EXPOSURE_US) ?
                   sta_pkg::RING_MIN_EXPOSURE_US : exposure_time_micro;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
      us_cnt   <= 32'h0000_0000;
    end else if (restart_exp || state != sta_pkg::STA_EXPOSE) begin
      // The edge cycle already belongs to the new interval, so whole microseconds come out exact.
      tick_cnt <= pulse_open ? sta_pkg::TICK_W'(1) : '0;
      us_cnt   <= 32'h0000_0000;
    end else if (us_tick) begin
      tick_cnt <= '0;
      us_cnt   <= us_cnt + 32'h0000_0001;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // Sequencer: decides when an exposure ends and what follows it.
  always_comb begin
    next_state  = state;
    gate        = 1'b0;
    restart_exp = 1'b0;
    unique case (state)
      sta_pkg::STA_IDLE: begin
        if (start_cmd) begin
          next_state = sta_pkg::STA_ARMED;
        end
      end
      sta_pkg::STA_ARMED: begin
        unique case (mode)
          sta_pkg::STA_MODE_GATED,
          sta_pkg::STA_MODE_LATCHED: if (trig_s) next_state = sta_pkg::STA_EXPOSE;
          sta_pkg::STA_MODE_PULSE:   if (trig_rise) next_state = sta_pkg::STA_EXPOSE;
          sta_pkg::STA_MODE_EDGE:    if (trig_edge) next_state = sta_pkg::STA_EXPOSE;
        endcase
      end
      sta_pkg::STA_EXPOSE: begin
        if (mode == sta_pkg::STA_MODE_PULSE) begin
          if (trig_rise) begin
            gate        = 1'b1;
            restart_exp = 1'b1;
          end
        end else if (us_tick && (us_cnt + 32'h0000_0001 >= exp_eff)) begin
          gate        = 1'b1;
          restart_exp = 1'b1;
          unique case (mode)
            sta_pkg::STA_MODE_GATED:   if (!trig_s) next_state = sta_pkg::STA_ARMED;
            sta_pkg::STA_MODE_LATCHED: next_state = sta_pkg::STA_EXPOSE;
            default:                   next_state = sta_pkg::STA_IDLE;
          endcase
        end
      end
      default: next_state = sta_pkg::STA_IDLE;
    endcase
    if (stop_cmd) begin
      next_state = sta_pkg::STA_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state                <= sta_pkg::STA_IDLE;
      readout_gate_pulse_o <= 1'b0;
    end else begin
      state                <= next_state;
      readout_gate_pulse_o <= gate;
    end
  end

  // Interval between consecutive trigger pulses, in whole microseconds.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      measured_us <= 32'h0000_0000;
    end else if (gate && mode == sta_pkg::STA_MODE_PULSE) begin
      measured_us <= us_cnt;
    end
  end

  // Pixel accumulation over the averaging window.
  assign avg_n     = (average == '0) ? sta_pkg::AVG_W'(1) : average;
  assign frame_end = (frame_len == 16'h0000 || frame_len > 16'(sta_pkg::FRAME_MAX)) ?
                     sta_pkg::IDX_W'(sta_pkg::FRAME_MAX - 1) : sta_pkg::IDX_W'(frame_len - 16'h0001);
  assign pix_take  = pix_valid_i & frame_active;
  assign last_pass = (avg_cnt + 1'b1 >= avg_n);
  assign last_pix  = (pix_idx == frame_end);
  assign acc_sum   = ((avg_cnt == '0) ? '0 : acc[pix_idx]) + {{(sta_pkg::ACC_W-sta_pkg::PIX_W){1'b0}}, pix_data_i};

  always_ff @(posedge clk_i) begin
    if (pix_take) begin
      acc[pix_idx] <= acc_sum;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_idx      <= '0;
      avg_cnt      <= '0;
      frame_active <= 1'b0;
    end else if (start_cmd) begin
      pix_idx      <= '0;
      avg_cnt      <= '0;
      frame_active <= 1'b0;
    end else if (readout_gate_pulse_o) begin
      pix_idx      <= '0;
      frame_active <= 1'b1;
    end else if (pix_take) begin
      pix_idx <= last_pix ? '0 : pix_idx + 1'b1;
      if (last_pix) begin
        frame_active <= 1'b0;
        avg_cnt      <= last_pass ? '0 : avg_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ring_wr_valid <= 1'b0;
      ring_wr_data  <= '0;
    end else begin
      ring_wr_valid <= pix_take & last_pass;
      ring_wr_data  <= avg_div(acc_sum, avg_n);
    end
  end

  sta_ring u_ring (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_valid_i (ring_wr_valid),
    .wr_data_i  (ring_wr_data),
    .rd_valid_o (bulk_valid_o),
    .rd_ready_i (bulk_ready_i),
    .rd_data_o  (bulk_data_o),
    .level_o    (ring_level),
    .drop_o     (ring_drop)
  );

  // Bulk transfers are cut into host-sized pieces; last marks the final word of each.
  assign xfer_end    = (xfer_len == 16'h0000) ? 16'h0000 : xfer_len - 16'h0001;
  assign bulk_last_o = bulk_valid_o & (xfer_cnt == xfer_end);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xfer_cnt <= 16'h0000;
    end else if (bulk_valid_o && bulk_ready_i) begin
      xfer_cnt <= (xfer_cnt >= xfer_end) ? 16'h0000 : xfer_cnt + 16'h0001;
    end
  end

endmodule : sta_acquire

// >>> bench/sta_acq_assertions.sv
// Port checker of the trigger and acquisition block.
// Assumes it is bound to sta_acquire and sees only that module's ports.
module sta_acq_chk (
  // Watched ports
  input wire logic                      clk_i,
  input wire logic                      rst_i,
  input wire logic                      wb_cyc_i,
  input wire logic                      wb_stb_i,
  input wire logic                      wb_ack_o,
  input wire logic [sta_pkg::DW-1:0]    wb_dat_o,
  input wire logic                      readout_gate_pulse_o,
  input wire logic                      bulk_valid_o,
  input wire logic                      bulk_ready_i,
  input wire logic [sta_pkg::PIX_W-1:0] bulk_data_o,
  input wire logic                      bulk_last_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] gap;
  // Saturates, so the first pulse after reset is never judged early.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap <= 16'hFFFF;
    end else if (readout_gate_pulse_o) begin
      gap <= 16'h0001;
    end else if (gap != 16'hFFFF) begin
      gap <= gap + 16'h0001;
    end
  end
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged after one cycle");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside acknowledge");
  gate_once_a: assert property (readout_gate_pulse_o |=> !readout_gate_pulse_o [*8])
    else $error("gate pulses too close");
  gate_gap_a: assert property (readout_gate_pulse_o |-> gap >= 16'd19999)
    else $error("exposure shorter than the minimum");
  bulk_hold_a: assert property (bulk_valid_o && !bulk_ready_i |=> bulk_valid_o && $stable(bulk_data_o))
    else $error("stalled bulk word changed");
  bulk_last_a: assert property (bulk_last_o |-> bulk_valid_o)
    else $error("last marker without valid word");
  gate_c: cover property (readout_gate_pulse_o);
  stall_c: cover property (bulk_valid_o && !bulk_ready_i);
  last_c: cover property (bulk_last_o && bulk_ready_i);
endmodule : sta_acq_chk

bind sta_acquire sta_acq_chk sta_acq_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .readout_gate_pulse_o(readout_gate_pulse_o), .bulk_valid_o(bulk_valid_o),
  .bulk_ready_i(bulk_ready_i), .bulk_data_o(bulk_data_o), .bulk_last_o(bulk_last_o)
);

// >>> bench/sta_partner.sv
// Far side model: a sensor front end sending a frame per gate pulse, and a bulk host.
// Assumes one-cycle gate pulses; pixel value is seed plus seven per frame plus index.
module sta_partner #(
  parameter int unsigned FRAME_LEN = 4
) (
  // Sensor side
  input  wire logic        clk_i,
  input  wire logic        gate_i,
  input  wire logic [15:0] seed_i,
  output logic             pix_valid_o,
  output logic [15:0]      pix_data_o,
  // Bulk host side
  input  wire logic        stall_i,
  output logic             bulk_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned frame_no = 0;
  int unsigned left = 0;
  int unsigned idx = 0;
  initial begin
    pix_valid_o = 1'b0;
    pix_data_o  = 16'h0000;
  end
  // Idle data toggles so a stale pixel can never pass for a fresh one.
  always @(posedge clk_i) begin
    if (left != 0) begin
      pix_valid_o <= 1'b1;
      pix_data_o  <= seed_i + 16'(frame_no * 7 + idx);
      idx = idx + 1;
      left = left - 1;
      if (left == 0) frame_no = frame_no + 1;
    end else begin
      pix_valid_o <= 1'b0;
      pix_data_o  <= ~pix_data_o;
    end
    if (gate_i) begin
      left = FRAME_LEN;
      idx = 0;
    end
  end
  assign bulk_ready_o = !stall_i;
endmodule : sta_partner

// >>> bench/tb_sta_acquire.sv
// Self-checking bench of the trigger and acquisition block.
// Assumes a 20 MHz clock; each exposure lasts at least 20000 cycles.
module tb_sta_acquire;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] WL_MIN = 32'h43C8_0000;
  localparam logic [31:0] WL_MAX = 32'h4461_0000;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, trigger_i = 1'b0, readout_gate_pulse_o, pix_valid_i, stall = 1'b1;
  logic [15:0] pix_data_i, bulk_data_o, pix_seed = 16'h0000;
  logic bulk_valid_o, bulk_ready_i, bulk_last_o;
  logic [31:0] rq[$];
  logic [16:0] bq[$];
  int errors = 0, comparisons = 0;
  always #25 clk_i = ~clk_i;
  sta_acquire #(.WL_MIN_NM(WL_MIN), .WL_MAX_NM(WL_MAX)) sta_acquire_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .trigger_i(trigger_i), .readout_gate_pulse_o(readout_gate_pulse_o),
    .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i), .bulk_valid_o(bulk_valid_o),
    .bulk_ready_i(bulk_ready_i), .bulk_data_o(bulk_data_o), .bulk_last_o(bulk_last_o));
  sta_partner #(.FRAME_LEN(4)) sta_partner_inst (
    .clk_i(clk_i), .gate_i(readout_gate_pulse_o), .seed_i(pix_seed), .pix_valid_o(pix_valid_i),
    .pix_data_o(pix_data_i), .stall_i(stall), .bulk_ready_o(bulk_ready_i));
  task automatic conclude();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t register read %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_bulk(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t bulk word %h expected %h", $time, got, exp);
    end
  endtask : cmp_bulk
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rq.push_back(exp);
    wb(1'b0, adr, 32'h0000_0000);
  endtask : rd
  task automatic wait_gate();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (readout_gate_pulse_o !== 1'b1 && n < 25000);
    if (n >= 25000) begin
      errors++;
      $display("ERROR %0t no gate pulse", $time);
    end
  endtask : wait_gate
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      cmp_reg(wb_dat_o, rq.size() != 0 ? rq.pop_front() : 32'hX);
    end
    if (bulk_valid_o === 1'b1 && bulk_ready_i === 1'b1) begin
      cmp_bulk({bulk_last_o, bulk_data_o}, bq.size() != 0 ? bq.pop_front() : 17'hX);
    end
  end
  initial begin
    #4750000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    logic [16:0] sum;
    logic [7:0] adr[8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h20, 8'h24, 8'h3C};
    logic [31:0] rst_v[8] = '{32'h3E8, 32'h1, 32'h826, 32'h100, 32'h0FA0_03E8, WL_MIN, WL_MAX, 32'h0};
    pix_seed = 16'($urandom(32'hE731)) & 16'h7FFF;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) rd(adr[i], rst_v[i]);
    wb(1'b1, 8'h1C, 32'h0000_0000);
    rd(8'h1C, 32'h0FA0_03E8);
    // Latched mode, two frames averaged, drain held off until the spectrum is stored.
    wb(1'b1, 8'h04, 32'h0000_0001);
    wb(1'b1, 8'h08, 32'h0000_0002);
    wb(1'b1, 8'h0C, 32'h0000_0004);
    wb(1'b1, 8'h10, 32'h0000_0002);
    wb(1'b1, 8'h00, 32'h0000_0101);
    rd(8'h14, 32'h0000_0001);
    trigger_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    trigger_i <= 1'b0;
    wait_gate();
    wait_gate();
    repeat (20) @(posedge clk_i);
    rd(8'h14, 32'h0004_0003);
    wb(1'b1, 8'h00, 32'h0000_0201);
    rd(8'h14, 32'h0004_0000);
    for (int i = 0; i < 4; i++) begin
      sum = 17'(pix_seed + 16'(i)) + 17'(pix_seed + 16'(7 + i));
      bq.push_back({1'(i % 2), sum[16:1]});
    end
    stall <= 1'b0;
    repeat (40) @(posedge clk_i);
    rd(8'h14, 32'h0000_0000);
    // Gated mode with the trigger dropping mid-exposure; the drain stays stalled.
    stall <= 1'b1;
    wb(1'b1, 8'h08, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0100);
    trigger_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    trigger_i <= 1'b0;
    wait_gate();
    repeat (20) @(posedge clk_i);
    rd(8'h14, 32'h0004_0001);
    wb(1'b1, 8'h00, 32'h0000_0200);
    // Pulse mode: rising edges 20020 cycles apart give 1001 us.
    wb(1'b1, 8'h00, 32'h0000_0102);
    for (int p = 0; p < 2; p++) begin
      trigger_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      trigger_i <= 1'b0;
      repeat (p == 0 ? 20010 : 50) @(posedge clk_i);
    end
    rd(8'h18, 32'h0000_03E9);
    wb(1'b1, 8'h00, 32'h0000_0200);
    // Single edge mode on the falling edge: a rising edge must leave it armed.
    wb(1'b1, 8'h00, 32'h0000_0107);
    trigger_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(8'h14, 32'h0008_0005);
    trigger_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(8'h14, 32'h0008_0003);
    wb(1'b1, 8'h00, 32'h0000_0200);
    conclude();
  end
endmodule : tb_sta_acquire
